// ---- ops_seq_consts.vh ----
// Constants for the security register, reset and suspend sequencer.
// Assumes a 50 MHz system clock; included by ops_seq.v only.
`ifndef OPS_SEQ_CONSTS_VH
`define OPS_SEQ_CONSTS_VH

// Opcodes
`define OPS_CMD_WR_EN 8'h06
`define OPS_CMD_WR_DIS 8'h04
`define OPS_CMD_OTP_PROG 8'h42
`define OPS_CMD_OTP_READ 8'h48
`define OPS_CMD_RST_EN 8'h66
`define OPS_CMD_RST 8'h99
`define OPS_CMD_SUSPEND 8'h75
`define OPS_CMD_RESUME 8'h7a

// Security register address fields
`define OPS_ADDR_HI_VAL 8'h00
`define OPS_ADDR_SEL_LO 4'h1
`define OPS_ADDR_SEL_HI 4'h3
`define OPS_ADDR_MID_VAL 3'h0
`define OPS_OFFS_W 9
`define OPS_PAGE_BYTES 256
`define OPS_MEM_BYTES 1536
`define OPS_MEM_RESET 8'hff

// Frame byte positions
`define OPS_BYTE_ADDR_LAST 3'h3
`define OPS_BYTE_DUMMY 3'h4
`define OPS_BYTE_SAT 3'h5

// Timing: figures in ns, counts in 50 MHz cycles
`define OPS_CLK_MHZ 50
`define OPS_T_RES_NS 200
`define OPS_T_SUS_NS 2000
`define OPS_T_RST_NS 30000
`define OPS_T_PP_NS 600000
`define OPS_T_SE_NS 45000000
`define OPS_RES_CYC ((`OPS_T_RES_NS * `OPS_CLK_MHZ) / 1000)
`define OPS_SUS_CYC ((`OPS_T_SUS_NS * `OPS_CLK_MHZ) / 1000)
`define OPS_RST_CYC ((`OPS_T_RST_NS * `OPS_CLK_MHZ + 999) / 1000)
`define OPS_PP_CYC ((`OPS_T_PP_NS * `OPS_CLK_MHZ + 999) / 1000)
`define OPS_SE_CYC ((`OPS_T_SE_NS / 1000) * `OPS_CLK_MHZ)

`endif

// ---- ops_seq.v ----
// Serial flash command sequencer: security register program and read,
// two-step software reset, program/erase suspend and resume.
// Assumes serial pins arrive asynchronously; main array control is same-clock logic.
`timescale 1ns/1ps
`include "ops_seq_consts.vh"
module ops_seq #(
	parameter [31:0] PROG_CYCLES = `OPS_PP_CYC,
	parameter [31:0] ERASE_CYCLES = `OPS_SE_CYC,
	parameter [31:0] RST_CYCLES = `OPS_RST_CYC
)(
	// Clock, reset, enable
	input wire clk_sys_i,
	input wire resetn_i,
	input wire ce_i,
	// Serial pins
	input wire cs_n_i,
	input wire sclk_i,
	input wire si_i,
	output wire so_o,
	output wire so_oe_o,
	// Lock bits
	input wire otp_lock_bit_one_i,
	input wire otp_lock_bit_two_i,
	input wire otp_lock_bit_three_i,
	// Main array operation requests
	input wire main_op_start_i,
	input wire main_op_erase_i,
	// Status
	output wire write_in_progress_flag_o,
	output wire write_enable_latch_o,
	output wire [1:0] suspend_flags_o,
	output wire reset_busy_o,
	output wire main_op_done_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RUN = 3'h1;
	localparam [2:0] ST_SUSP_WAIT = 3'h2;
	localparam [2:0] ST_SUSP = 3'h3;
	localparam [2:0] ST_RES_WAIT = 3'h4;
	localparam [2:0] ST_RST = 3'h5;
	localparam [1:0] K_NONE = 2'h0;
	localparam [1:0] K_OTP = 2'h1;
	localparam [1:0] K_PROG = 2'h2;
	localparam [1:0] K_ERASE = 2'h3;
	localparam [31:0] SUS_CYC = `OPS_SUS_CYC;
	localparam [31:0] RES_CYC = `OPS_RES_CYC;
	// Pin synchronisers
	reg cs_s1_ff, cs_s2_ff, cs_d_ff;
	reg sclk_s1_ff, sclk_s2_ff, sclk_d_ff;
	reg si_s1_ff, si_s2_ff;
	// Frame state
	reg [2:0] bitc_ff, bytec_ff, obit_ff;
	reg [7:0] in_sh_ff, opcode_ff, wr_off_ff, out_sh_ff;
	reg [23:0] addr_ff, rd_addr_ff;
	reg reading_ff, so_ff, so_oe_ff;
	reg [7:0] pbuf [0:`OPS_PAGE_BYTES-1];
	reg [`OPS_PAGE_BYTES-1:0] pmask_ff;
	// Operation state
	reg [2:0] state_ff, prog_base_ff;
	reg [1:0] kind_ff, saved_kind_ff, susp_ff;
	reg [31:0] cnt_ff, saved_cnt_ff, lat_ff;
	reg wip_ff, wel_ff, rst_en_ff, done_ff, rst_busy_ff;
	reg [7:0] mem [0:`OPS_MEM_BYTES-1];
	integer i;
	// Security register address check
	function addr_ok(input [23:0] a);
		addr_ok = (a[23:16] == `OPS_ADDR_HI_VAL) && (a[15:12] >= `OPS_ADDR_SEL_LO) &&
			(a[15:12] <= `OPS_ADDR_SEL_HI) && (a[11:9] == `OPS_ADDR_MID_VAL);
	endfunction
	// Flat storage index: register, page, byte
	function [10:0] mem_idx(input [23:0] a);
		mem_idx = {a[13:12] - 2'h1, a[8:0]};
	endfunction
	wire sclk_rise = sclk_s2_ff & ~sclk_d_ff;
	wire sclk_fall = ~sclk_s2_ff & sclk_d_ff;
	wire cs_rise = cs_s2_ff & ~cs_d_ff;
	wire [7:0] nxt_byte = {in_sh_ff[6:0], si_s2_ff};
	wire buf_free = (kind_ff != K_OTP);
	wire rst_busy = rst_busy_ff;
	wire [23:0] rd_next = {rd_addr_ff[23:9], rd_addr_ff[8:0] + 9'h001};
	wire [7:0] rd_first = addr_ok(addr_ff) ? mem[mem_idx(addr_ff)] : `OPS_MEM_RESET;
	wire [7:0] rd_second = addr_ok(rd_next) ? mem[mem_idx(rd_next)] : `OPS_MEM_RESET;
	wire locked = (addr_ff[13:12] == 2'h1 && otp_lock_bit_one_i) ||
		(addr_ff[13:12] == 2'h2 && otp_lock_bit_two_i) ||
		(addr_ff[13:12] == 2'h3 && otp_lock_bit_three_i);
	// Frame-end decode
	wire whole = (bitc_ff == 3'h0);
	wire one_byte = whole && (bytec_ff == 3'h1);
	wire fr_end = cs_rise && !rst_busy;
	wire otp_ok = whole && (bytec_ff == `OPS_BYTE_SAT) && wel_ff && addr_ok(addr_ff) &&
		!locked && (state_ff == ST_IDLE || (state_ff == ST_SUSP && susp_ff == 2'b10));
	wire do_otp = fr_end && (opcode_ff == `OPS_CMD_OTP_PROG) && otp_ok;
	wire do_rst = fr_end && one_byte && rst_en_ff && (opcode_ff == `OPS_CMD_RST);
	wire do_susp = fr_end && one_byte && (opcode_ff == `OPS_CMD_SUSPEND) && state_ff == ST_RUN &&
		wip_ff && susp_ff == 2'b00 && (kind_ff == K_PROG || kind_ff == K_ERASE);
	wire do_res = fr_end && one_byte && (opcode_ff == `OPS_CMD_RESUME) &&
		state_ff == ST_SUSP && susp_ff != 2'b00 && !wip_ff;
	wire main_ok = main_op_start_i && wel_ff && (state_ff == ST_IDLE ||
		(state_ff == ST_SUSP && susp_ff == 2'b10 && !main_op_erase_i));
	// Serial frame handling
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			cs_d_ff <= 1'b1;
			sclk_s1_ff <= 1'b0;
			sclk_s2_ff <= 1'b0;
			sclk_d_ff <= 1'b0;
			si_s1_ff <= 1'b0;
			si_s2_ff <= 1'b0;
			bitc_ff <= 3'h0;
			bytec_ff <= 3'h0;
			in_sh_ff <= 8'h00;
			opcode_ff <= 8'h00;
			addr_ff <= 24'h000000;
			wr_off_ff <= 8'h00;
			reading_ff <= 1'b0;
			obit_ff <= 3'h0;
			out_sh_ff <= 8'h00;
			rd_addr_ff <= 24'h000000;
			so_ff <= 1'b0;
			so_oe_ff <= 1'b0;
			pmask_ff <= {`OPS_PAGE_BYTES{1'b0}};
			for (i = 0; i < `OPS_PAGE_BYTES; i = i + 1)
				pbuf[i] <= `OPS_MEM_RESET;
		end
		else if (ce_i)
		begin
			cs_s1_ff <= cs_n_i;
			cs_s2_ff <= cs_s1_ff;
			cs_d_ff <= cs_s2_ff;
			sclk_s1_ff <= sclk_i;
			sclk_s2_ff <= sclk_s1_ff;
			sclk_d_ff <= sclk_s2_ff;
			si_s1_ff <= si_i;
			si_s2_ff <= si_s1_ff;
			if (cs_s2_ff || do_rst)
			begin
				bitc_ff <= 3'h0;
				bytec_ff <= 3'h0;
				reading_ff <= 1'b0;
				so_oe_ff <= 1'b0;
			end
			else
			begin
				if (sclk_rise)
				begin
					in_sh_ff <= nxt_byte;
					bitc_ff <= bitc_ff + 3'h1;
					if (bitc_ff == 3'h7)
					begin
						if (bytec_ff != `OPS_BYTE_SAT)
							bytec_ff <= bytec_ff + 3'h1;
						if (bytec_ff == 3'h0)
						begin
							opcode_ff <= nxt_byte;
							if (nxt_byte == `OPS_CMD_OTP_PROG && buf_free)
								pmask_ff <= {`OPS_PAGE_BYTES{1'b0}};
						end
						else if (bytec_ff <= `OPS_BYTE_ADDR_LAST)
						begin
							addr_ff <= {addr_ff[15:0], nxt_byte};
							wr_off_ff <= nxt_byte;
						end
						else if (opcode_ff == `OPS_CMD_OTP_PROG && buf_free)
						begin
							pbuf[wr_off_ff] <= nxt_byte;
							pmask_ff[wr_off_ff] <= 1'b1;
							wr_off_ff <= wr_off_ff + 8'h01;
						end
						else if (opcode_ff == `OPS_CMD_OTP_READ && bytec_ff == `OPS_BYTE_DUMMY &&
							!rst_busy)
						begin
							reading_ff <= 1'b1;
							rd_addr_ff <= addr_ff;
							out_sh_ff <= rd_first;
							obit_ff <= 3'h0;
						end
					end
				end
				if (sclk_fall && reading_ff)
				begin
					so_ff <= out_sh_ff[7];
					so_oe_ff <= 1'b1;
					obit_ff <= obit_ff + 3'h1;
					if (obit_ff == 3'h7)
					begin
						rd_addr_ff <= rd_next;
						out_sh_ff <= rd_second;
					end
					else
						out_sh_ff <= {out_sh_ff[6:0], 1'b0};
				end
			end
		end
	end
	// Operation sequencer
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff <= ST_IDLE;
			kind_ff <= K_NONE;
			cnt_ff <= 32'h00000000;
			saved_kind_ff <= K_NONE;
			saved_cnt_ff <= 32'h00000000;
			lat_ff <= 32'h00000000;
			wip_ff <= 1'b0;
			wel_ff <= 1'b0;
			susp_ff <= 2'b00;
			rst_en_ff <= 1'b0;
			prog_base_ff <= 3'h0;
			done_ff <= 1'b0;
			rst_busy_ff <= 1'b0;
			for (i = 0; i < `OPS_MEM_BYTES; i = i + 1)
				mem[i] <= `OPS_MEM_RESET;
		end
		else if (ce_i)
		begin
			done_ff <= 1'b0;
			if (fr_end)
				rst_en_ff <= one_byte && (opcode_ff == `OPS_CMD_RST_EN);
			if (do_rst)
			begin
				state_ff <= ST_RST;
				kind_ff <= K_NONE;
				saved_kind_ff <= K_NONE;
				wip_ff <= 1'b0;
				wel_ff <= 1'b0;
				susp_ff <= 2'b00;
				rst_en_ff <= 1'b0;
				lat_ff <= RST_CYCLES;
				rst_busy_ff <= 1'b1;
			end
			else
			begin
				if (fr_end && one_byte && opcode_ff == `OPS_CMD_WR_EN)
					wel_ff <= 1'b1;
				else if (fr_end && one_byte && opcode_ff == `OPS_CMD_WR_DIS)
					wel_ff <= 1'b0;
				case (state_ff)
					ST_IDLE, ST_SUSP:
					begin
						if (do_otp)
						begin
							state_ff <= ST_RUN;
							kind_ff <= K_OTP;
							cnt_ff <= PROG_CYCLES;
							prog_base_ff <= {addr_ff[13:12] - 2'h1, addr_ff[8]};
							wip_ff <= 1'b1;
							wel_ff <= 1'b0;
						end
						else if (do_res)
						begin
							susp_ff <= 2'b00;
							state_ff <= ST_RES_WAIT;
							lat_ff <= RES_CYC;
						end
						else if (main_ok)
						begin
							state_ff <= ST_RUN;
							kind_ff <= main_op_erase_i ? K_ERASE : K_PROG;
							cnt_ff <= main_op_erase_i ? ERASE_CYCLES : PROG_CYCLES;
							wip_ff <= 1'b1;
							wel_ff <= 1'b0;
						end
					end
					ST_RUN:
					begin
						if (do_susp)
						begin
							susp_ff <= (kind_ff == K_ERASE) ? 2'b10 : 2'b01;
							state_ff <= ST_SUSP_WAIT;
							lat_ff <= SUS_CYC;
						end
						else if (cnt_ff <= 32'h00000001)
						begin
							if (kind_ff == K_OTP)
							begin
								for (i = 0; i < `OPS_PAGE_BYTES; i = i + 1)
									if (pmask_ff[i])
										mem[{prog_base_ff, i[7:0]}] <=
											mem[{prog_base_ff, i[7:0]}] & pbuf[i];
							end
							else
								done_ff <= 1'b1;
							kind_ff <= K_NONE;
							wip_ff <= 1'b0;
							state_ff <= (susp_ff != 2'b00) ? ST_SUSP : ST_IDLE;
						end
						else
							cnt_ff <= cnt_ff - 32'h00000001;
					end
					ST_SUSP_WAIT:
					begin
						if (lat_ff <= 32'h00000001)
						begin
							wip_ff <= 1'b0;
							saved_kind_ff <= kind_ff;
							saved_cnt_ff <= cnt_ff;
							kind_ff <= K_NONE;
							state_ff <= ST_SUSP;
						end
						else
							lat_ff <= lat_ff - 32'h00000001;
					end
					ST_RES_WAIT:
					begin
						if (lat_ff <= 32'h00000001)
						begin
							wip_ff <= 1'b1;
							kind_ff <= saved_kind_ff;
							cnt_ff <= saved_cnt_ff;
							saved_kind_ff <= K_NONE;
							state_ff <= ST_RUN;
						end
						else
							lat_ff <= lat_ff - 32'h00000001;
					end
					ST_RST:
					begin
						rst_busy_ff <= (lat_ff > 32'h00000001);
						if (lat_ff <= 32'h00000001)
							state_ff <= ST_IDLE;
						else
							lat_ff <= lat_ff - 32'h00000001;
					end
					default:
						state_ff <= ST_IDLE;
				endcase
			end
		end
	end
	assign so_o = so_ff;
	assign so_oe_o = so_oe_ff;
	assign write_in_progress_flag_o = wip_ff;
	assign write_enable_latch_o = wel_ff;
	assign suspend_flags_o = susp_ff;
	assign reset_busy_o = rst_busy_ff;
	assign main_op_done_o = done_ff;
endmodule // ops_seq

// ---- ops_seq_assertions.sv ----
// Checker for the sequencer status flags and serial output enable.
// Assumes the ops_seq ports; bound to every ops_seq instance.
`timescale 1ns/1ps
module ops_chk #(
	parameter [31:0] RST_CYCLES = 32'd10
)(
	// Clock and reset
	input wire clk_sys_i,
	input wire resetn_i,
	// Pins and status
	input wire cs_n_i,
	input wire so_oe_o,
	input wire write_in_progress_flag_o,
	input wire write_enable_latch_o,
	input wire [1:0] suspend_flags_o,
	input wire reset_busy_o,
	input wire main_op_done_o
);
	wire write_in_progress_flag = write_in_progress_flag_o;
	wire sus = |suspend_flags_o;
	reg [15:0] rb_cnt_ff;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	// Length of the reset recovery window
	always @(posedge clk_sys_i or negedge resetn_i)
		if (!resetn_i)
			rb_cnt_ff <= 16'h0;
		else
			rb_cnt_ff <= reset_busy_o ? rb_cnt_ff + 16'h1 : 16'h0;
	AST_OE_OFF: assert property (cs_n_i [*5] |-> !so_oe_o)
		else $error("output enable high while deselected");
	AST_SUS_ONLY_BUSY: assert property ($rose(sus) |-> $past(write_in_progress_flag))
		else $error("suspend taken while idle");
	AST_SUS_WIP_DROP: assert property ($rose(sus) |-> ##[1:120] !write_in_progress_flag)
		else $error("busy not dropped after suspend");
	AST_RES_ONLY_SUS: assert property ($fell(sus) |-> !$past(write_in_progress_flag))
		else $error("resume taken while busy");
	AST_RES_WIP: assert property ($fell(sus) |-> ##[1:12] (write_in_progress_flag || reset_busy_o))
		else $error("busy not restored after resume");
	AST_WEL_CLR: assert property ($rose(write_in_progress_flag) |-> !write_enable_latch_o)
		else $error("write enable still set in cycle");
	AST_RST_HOLD: assert property (reset_busy_o |-> !write_in_progress_flag && !sus && !write_enable_latch_o)
		else $error("state changed during reset recovery");
	AST_RST_LEN: assert property ($fell(reset_busy_o) |->
		rb_cnt_ff + 16'h1 >= RST_CYCLES && rb_cnt_ff <= RST_CYCLES + 1)
		else $error("reset recovery length wrong");
	AST_DONE: assert property (main_op_done_o |-> ##[0:1] !write_in_progress_flag)
		else $error("busy after done");
	COV_SUS: cover property ($rose(sus));
	COV_RES: cover property ($fell(sus) && !reset_busy_o);
	COV_RST: cover property ($rose(reset_busy_o));
endmodule // ops_chk
bind ops_seq ops_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (.clk_sys_i, .resetn_i, .cs_n_i, .so_oe_o,
	.write_in_progress_flag_o, .write_enable_latch_o, .suspend_flags_o, .reset_busy_o,
	.main_op_done_o);

// ---- ops_host.sv ----
// Serial host model: sends whole frames, mode 0, MSB first.
// Assumes the system clock; serial clock period is 8 clocks.
`timescale 1ns/1ps
module ops_host (
	// Clock
	input wire clk_i,
	// Serial pins
	output logic cs_n_o,
	output logic sclk_o,
	output logic si_o,
	input wire so_i
);
	logic [7:0] rx_q [$];
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b0;
	end
	// One frame: tx bytes, then nrx bytes read back
	task automatic xfer(input logic [7:0] tx [$], input int nrx);
		logic [7:0] b;
		rx_q.delete();
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		for (int i = 0; i < tx.size() + nrx; i++)
		begin
			b = (i < tx.size()) ? tx[i] : 8'h00;
			for (int k = 7; k >= 0; k--)
			begin
				si_o <= b[k];
				repeat (5) @(posedge clk_i);
				b[k] = so_i;
				sclk_o <= 1'b1;
				repeat (3) @(posedge clk_i);
				sclk_o <= 1'b0;
			end
			if (i >= tx.size())
				rx_q.push_back(b);
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		si_o <= ~si_o;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // ops_host

// ---- tb.sv ----
// Testbench: scenario tasks drive the sequencer through the host model.
// Assumes shortened cycle counts on the design.
`timescale 1ns/1ps
`define CHK(a, b) \
	begin \
		num_checks++; \
		if ((a) !== (b)) \
		begin \
			error_cnt++; \
			$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module tb;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic lk1 = 1'b0;
	logic lk2 = 1'b0;
	logic lk3 = 1'b0;
	logic start = 1'b0;
	logic erase = 1'b0;
	wire cs_n, sclk, si, so, oe, write_in_progress_flag, write_enable_latch, rbusy, done;
	wire [1:0] sus;
	int error_cnt = 0;
	int num_checks = 0;
	initial
		forever #10 clk_sys_i = ~clk_sys_i;
	ops_seq #(.PROG_CYCLES(1000), .ERASE_CYCLES(1500), .RST_CYCLES(200)) i_dut (
		.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ce_i(1'b1), .cs_n_i(cs_n),
		.sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(oe), .otp_lock_bit_one_i(lk1),
		.otp_lock_bit_two_i(lk2), .otp_lock_bit_three_i(lk3), .main_op_start_i(start),
		.main_op_erase_i(erase), .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch),
		.suspend_flags_o(sus), .reset_busy_o(rbusy), .main_op_done_o(done));
	ops_host i_host (.clk_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
		.so_i(oe ? so : ~so));
	task automatic wait_wip(input logic v);
		for (int i = 0; i < 4000 && write_in_progress_flag !== v; i++)
			@(posedge clk_sys_i);
		`CHK(write_in_progress_flag, v)
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [7:0] e0, e1, e2);
		i_host.xfer('{8'h48, 8'h00, a[15:8], a[7:0], 8'h00}, 3);
		`CHK(i_host.rx_q[0], e0)
		`CHK(i_host.rx_q[1], e1)
		`CHK(i_host.rx_q[2], e2)
		`CHK(oe, 1'b0)
	endtask
	task automatic go(input logic e);
		i_host.xfer('{8'h06}, 0);
		@(posedge clk_sys_i);
		start <= 1'b1;
		erase <= e;
		@(posedge clk_sys_i);
		start <= 1'b0;
	endtask
	task automatic t_prog();
		i_host.xfer('{8'h06}, 0);
		`CHK(write_enable_latch, 1'b1)
		i_host.xfer('{8'h42, 8'h00, 8'h11, 8'hfe, 8'ha5, 8'h3c}, 0);
		`CHK({write_in_progress_flag, write_enable_latch}, 2'b10)
		wait_wip(1'b0);
		i_host.xfer('{8'h06}, 0);
		i_host.xfer('{8'h42, 8'h00, 8'h10, 8'h00, 8'h77}, 0);
		wait_wip(1'b0);
		rd_chk(16'h11fe, 8'ha5, 8'h3c, 8'h77);
	endtask
	task automatic t_lock();
		lk2 <= 1'b1;
		i_host.xfer('{8'h06}, 0);
		i_host.xfer('{8'h42, 8'h00, 8'h20, 8'h00, 8'h00}, 0);
		`CHK({write_in_progress_flag, write_enable_latch}, 2'b01)
		i_host.xfer('{8'h04}, 0);
		i_host.xfer('{8'h42, 8'h00, 8'h30, 8'h00, 8'h00}, 0);
		`CHK(write_in_progress_flag, 1'b0)
		rd_chk(16'h2000, 8'hff, 8'hff, 8'hff);
		rd_chk(16'h3000, 8'hff, 8'hff, 8'hff);
		lk2 <= 1'b0;
	endtask
	task automatic t_susp();
		i_host.xfer('{8'h75}, 0);
		`CHK(sus, 2'b00)
		go(1'b0);
		wait_wip(1'b1);
		i_host.xfer('{8'h7a}, 0);
		`CHK(sus, 2'b00)
		i_host.xfer('{8'h75}, 0);
		`CHK(sus, 2'b01)
		wait_wip(1'b0);
		i_host.xfer('{8'h06}, 0);
		i_host.xfer('{8'h42, 8'h00, 8'h10, 8'h00, 8'h00}, 0);
		`CHK({write_in_progress_flag, sus}, 3'b001)
		i_host.xfer('{8'h04}, 0);
		i_host.xfer('{8'h7a}, 0);
		`CHK(sus, 2'b00)
		for (int i = 0; i < 4000 && done !== 1'b1; i++)
			@(posedge clk_sys_i);
		`CHK(done, 1'b1)
	endtask
	task automatic t_rst();
		go(1'b1);
		wait_wip(1'b1);
		i_host.xfer('{8'h75}, 0);
		wait_wip(1'b0);
		`CHK(sus, 2'b10)
		go(1'b1);
		`CHK({write_in_progress_flag, sus, write_enable_latch}, 4'b0101)
		i_host.xfer('{8'h66}, 0);
		i_host.xfer('{8'h04}, 0);
		i_host.xfer('{8'h99}, 0);
		`CHK({rbusy, sus}, 3'b010)
		i_host.xfer('{8'h66}, 0);
		i_host.xfer('{8'h99}, 0);
		`CHK({rbusy, sus, write_enable_latch, write_in_progress_flag}, 5'b10000)
		i_host.xfer('{8'h06}, 0);
		`CHK(write_enable_latch, 1'b0)
		for (int i = 0; i < 400 && rbusy !== 1'b0; i++)
			@(posedge clk_sys_i);
		i_host.xfer('{8'h06}, 0);
		`CHK(write_enable_latch, 1'b1)
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_prog();
		t_lock();
		t_susp();
		t_rst();
		summarize();
	end
	initial
	begin
		#1000000;
		error_cnt++;
		summarize();
	end
endmodule // tb
